// >>> i2cm_pkg.sv
// Purpose: shared constants and types for the i2c master data controller
// Assumes: 125 MHz system clock, 8-bit special-function register port
// Notes: offsets are the byte addresses seen by the processor
package i2cm_pkg;
    localparam logic [15:0] I2CM_TARGET_OFF = 16'hff80;
    localparam logic [15:0] I2CM_TX_PRI_OFF = 16'hff81;
    localparam logic [15:0] I2CM_TX_SEC_OFF = 16'hff82;
    localparam logic [15:0] I2CM_RX_PRI_OFF = 16'hff83;
    localparam logic [15:0] I2CM_RX_SEC_OFF = 16'hff84;
    localparam logic [15:0] I2CM_CTRL_OFF = 16'hff85;
    localparam logic [7:0] I2CM_TARGET_RST = 8'h00;
    localparam logic [7:0] I2CM_DATA_RST = 8'h00;
    localparam logic [7:0] I2CM_CTRL_RST = 8'h00;
    localparam int I2CM_DIR_POS = 0;
    localparam int I2CM_ADDR_LSB = 1;
    localparam int I2CM_LEN_POS = 0;
    localparam int I2CM_START_POS = 1;
    localparam int I2CM_ACKERR_POS = 2;
    localparam int I2CM_CLK_NS = 8;
    // 400 kHz time base: 2500 ns per bus bit, four quarters per bit
    localparam int I2CM_QTR_NS = 625;
    localparam int I2CM_QTR_CYCLES = (I2CM_QTR_NS + I2CM_CLK_NS - 1) / I2CM_CLK_NS;
    localparam int I2CM_BUF_DEPTH = 2;

    typedef struct packed {
        logic second;
        logic [7:0] data;
    } i2cm_rx_word_type;

    typedef enum {
        I2CM_IDLE, I2CM_START, I2CM_SHIFT, I2CM_ACK, I2CM_PUSH, I2CM_STOP, I2CM_DONE
    } i2cm_state_type;
endpackage

// >>> i2cm_buf2.sv
// Purpose: small valid/ready buffer for received bytes
// Assumes: single clock, depth of at least two
// Notes: full and empty are exact; the filler stalls on full
`timescale 1ns/1ps
`default_nettype none
module i2cm_buf2 #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [PW:0] cnt_reg, cnt_next;
    logic push, pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_next = push ? bump(wr_reg) : wr_reg;
        rd_next = pop ? bump(rd_reg) : rd_reg;
        cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage needs no reset; it is only read while counted valid
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
endmodule
`default_nettype wire

// >>> i2cm_core.sv
// Purpose: register-driven i2c master moving one or two data bytes per frame
// Assumes: processor register port on clk_sys; open-drain bus pins outside
// Notes: no arbitration; slave clock stretching is honoured
//
// Overview of operation
// - first written byte comes from tx_primary_byte
// - two-byte length sends tx_secondary_byte second
// - first read byte lands in rx_primary_byte
// - non-zero slave acknowledge sets ack_error_flag
// - ack_error_flag clears when a transaction starts
// - start_busy_bit reads one until frame ends
// - length bit picks one or two bytes
// - second read byte lands in rx_secondary_byte
// - target holds seven-bit address plus direction
// - transfer_done_flag sets at end, clears at start
// - bus timing from a 400 kHz time base
`timescale 1ns/1ps
`default_nettype none
module i2cm_core
    import i2cm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [15:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic transfer_done_flag,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    logic [7:0] target_reg, target_next, tx_pri_reg, tx_pri_next, tx_sec_reg, tx_sec_next;
    logic [7:0] rx_pri_reg, rx_pri_next, rx_sec_reg, rx_sec_next, rdata_reg, rdata_next;
    logic len_reg, len_next;
    logic [1:0] scl_sync_reg, sda_sync_reg;
    i2cm_state_type state_reg, state_next;
    logic [6:0] qcnt_reg, qcnt_next;
    logic [1:0] q_reg, q_next;
    logic [2:0] bit_reg, bit_next;
    logic [1:0] byte_reg, byte_next;
    logic [7:0] shift_reg, shift_next, rxsh_reg, rxsh_next;
    logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
    logic ackerr_reg, ackerr_next, busy_reg, busy_next, done_reg, done_next;
    logic dir_reg, dir_next, two_reg, two_next;
    logic start_wr, tick, counting, sending, last, scl_s, sda_s;
    logic in_valid, in_ready, out_valid, out_ready;
    i2cm_rx_word_type push_word, out_word;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction

    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign start_wr = sfr_wr && hit(sfr_addr, I2CM_CTRL_OFF) && sfr_wdata[I2CM_START_POS] && !busy_reg;
    assign sending = (byte_reg == 2'd0) || !dir_reg;
    assign last = (byte_reg == (two_reg ? 2'd2 : 2'd1));
    assign counting = (state_reg == I2CM_START) || (state_reg == I2CM_SHIFT) ||
                      (state_reg == I2CM_ACK) || (state_reg == I2CM_STOP);
    assign tick = counting && (qcnt_reg == 7'(I2CM_QTR_CYCLES - 1));
    assign in_valid = (state_reg == I2CM_PUSH);
    // drain pauses while the processor reads a received byte, so a read never tears
    assign out_ready = !(sfr_rd && (hit(sfr_addr, I2CM_RX_PRI_OFF) || hit(sfr_addr, I2CM_RX_SEC_OFF)));

    i2cm_buf2 #(
        .WIDTH($bits(i2cm_rx_word_type)),
        .DEPTH(I2CM_BUF_DEPTH)
    ) rx_buf (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(push_word),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_word)
    );

    always_comb begin
        target_next = target_reg;
        tx_pri_next = tx_pri_reg;
        tx_sec_next = tx_sec_reg;
        len_next = len_reg;
        rx_pri_next = rx_pri_reg;
        rx_sec_next = rx_sec_reg;
        rdata_next = rdata_reg;
        if (sfr_wr && hit(sfr_addr, I2CM_TARGET_OFF)) target_next = sfr_wdata;
        if (sfr_wr && hit(sfr_addr, I2CM_TX_PRI_OFF)) tx_pri_next = sfr_wdata;
        if (sfr_wr && hit(sfr_addr, I2CM_TX_SEC_OFF)) tx_sec_next = sfr_wdata;
        // length is frozen during a frame; it is latched again at start
        if (sfr_wr && hit(sfr_addr, I2CM_CTRL_OFF) && !busy_reg) len_next = sfr_wdata[I2CM_LEN_POS];
        if (out_valid && out_ready) begin
            if (out_word.second) rx_sec_next = out_word.data;
            else rx_pri_next = out_word.data;
        end
        if (sfr_rd) begin
            rdata_next = 8'h00;
            if (hit(sfr_addr, I2CM_TARGET_OFF)) rdata_next = target_reg;
            if (hit(sfr_addr, I2CM_TX_PRI_OFF)) rdata_next = tx_pri_reg;
            if (hit(sfr_addr, I2CM_TX_SEC_OFF)) rdata_next = tx_sec_reg;
            if (hit(sfr_addr, I2CM_RX_PRI_OFF)) rdata_next = rx_pri_reg;
            if (hit(sfr_addr, I2CM_RX_SEC_OFF)) rdata_next = rx_sec_reg;
            if (hit(sfr_addr, I2CM_CTRL_OFF)) begin
                rdata_next[I2CM_LEN_POS] = len_reg;
                rdata_next[I2CM_START_POS] = busy_reg;
                rdata_next[I2CM_ACKERR_POS] = ackerr_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            target_reg <= I2CM_TARGET_RST;
            tx_pri_reg <= I2CM_DATA_RST;
            tx_sec_reg <= I2CM_DATA_RST;
            rx_pri_reg <= I2CM_DATA_RST;
            rx_sec_reg <= I2CM_DATA_RST;
            len_reg <= I2CM_CTRL_RST[I2CM_LEN_POS];
            rdata_reg <= 8'h00;
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
        end else begin
            target_reg <= target_next;
            tx_pri_reg <= tx_pri_next;
            tx_sec_reg <= tx_sec_next;
            rx_pri_reg <= rx_pri_next;
            rx_sec_reg <= rx_sec_next;
            len_reg <= len_next;
            rdata_reg <= rdata_next;
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
        end
    end

    always_comb begin
        state_next = state_reg;
        qcnt_next = qcnt_reg;
        q_next = q_reg;
        bit_next = bit_reg;
        byte_next = byte_reg;
        shift_next = shift_reg;
        rxsh_next = rxsh_reg;
        scl_oe_next = scl_oe_reg;
        sda_oe_next = sda_oe_reg;
        ackerr_next = ackerr_reg;
        busy_next = busy_reg;
        done_next = done_reg;
        dir_next = dir_reg;
        two_next = two_reg;
        push_word = '{second: (byte_reg == 2'd2), data: rxsh_reg};
        // a released clock still held low by the slave stretches the quarter
        if (counting && !(!scl_oe_reg && !scl_s)) begin
            qcnt_next = tick ? 7'd0 : qcnt_reg + 7'd1;
            if (tick) q_next = q_reg + 2'd1;
        end
        case (state_reg)
            I2CM_IDLE: begin
                scl_oe_next = 1'b0;
                sda_oe_next = 1'b0;
                if (start_wr) begin
                    busy_next = 1'b1;
                    ackerr_next = 1'b0;
                    done_next = 1'b0;
                    dir_next = target_reg[I2CM_DIR_POS];
                    // the length written with the start bit applies to this frame
                    two_next = sfr_wdata[I2CM_LEN_POS];
                    shift_next = target_reg;
                    byte_next = 2'd0;
                    qcnt_next = 7'd0;
                    q_next = 2'd0;
                    state_next = I2CM_START;
                end
            end
            I2CM_START: begin
                if (tick && q_reg == 2'd1) sda_oe_next = 1'b1;
                if (tick && q_reg == 2'd3) begin
                    scl_oe_next = 1'b1;
                    bit_next = 3'd7;
                    state_next = I2CM_SHIFT;
                end
            end
            I2CM_SHIFT: begin
                if (tick) begin
                    case (q_reg)
                        2'd0: sda_oe_next = sending ? !shift_reg[bit_reg] : 1'b0;
                        2'd1: scl_oe_next = 1'b0;
                        2'd2: rxsh_next = {rxsh_reg[6:0], sda_s};
                        default: begin
                            scl_oe_next = 1'b1;
                            bit_next = bit_reg - 3'd1;
                            if (bit_reg == 3'd0) state_next = I2CM_ACK;
                        end
                    endcase
                end
            end
            I2CM_ACK: begin
                if (tick) begin
                    case (q_reg)
                        2'd0: sda_oe_next = sending ? 1'b0 : !last;
                        2'd1: scl_oe_next = 1'b0;
                        2'd2: if (sending && sda_s) ackerr_next = 1'b1;
                        default: begin
                            scl_oe_next = 1'b1;
                            bit_next = 3'd7;
                            if (ackerr_reg) begin
                                state_next = I2CM_STOP;
                            end else if (!sending) begin
                                state_next = I2CM_PUSH;
                            end else if (last) begin
                                state_next = I2CM_STOP;
                            end else begin
                                byte_next = byte_reg + 2'd1;
                                shift_next = (byte_reg == 2'd0) ? tx_pri_reg : tx_sec_reg;
                                state_next = I2CM_SHIFT;
                            end
                        end
                    endcase
                end
            end
            I2CM_PUSH: begin
                if (in_ready) begin
                    qcnt_next = 7'd0;
                    q_next = 2'd0;
                    if (last) begin
                        state_next = I2CM_STOP;
                    end else begin
                        byte_next = byte_reg + 2'd1;
                        state_next = I2CM_SHIFT;
                    end
                end
            end
            I2CM_STOP: begin
                if (tick) begin
                    case (q_reg)
                        2'd0: sda_oe_next = 1'b1;
                        2'd1: scl_oe_next = 1'b0;
                        2'd2: sda_oe_next = 1'b0;
                        default: state_next = I2CM_DONE;
                    endcase
                end
            end
            I2CM_DONE: begin
                // busy holds until every received byte is in its register
                if (!out_valid) begin
                    busy_next = 1'b0;
                    done_next = 1'b1;
                    state_next = I2CM_IDLE;
                end
            end
            default: state_next = I2CM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= I2CM_IDLE;
            qcnt_reg <= 7'd0;
            q_reg <= 2'd0;
            bit_reg <= 3'd7;
            byte_reg <= 2'd0;
            shift_reg <= 8'h00;
            rxsh_reg <= 8'h00;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            ackerr_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            dir_reg <= 1'b0;
            two_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            qcnt_reg <= qcnt_next;
            q_reg <= q_next;
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            shift_reg <= shift_next;
            rxsh_reg <= rxsh_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
            ackerr_reg <= ackerr_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            dir_reg <= dir_next;
            two_reg <= two_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign transfer_done_flag = done_reg;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    start_launch_a: assert property (start_wr |=> busy_reg && state_reg == I2CM_START)
        else $error("start write did not launch a frame");
    busy_end_a: assert property ($fell(busy_reg) |-> done_reg && $past(state_reg) == I2CM_DONE)
        else $error("busy fell without completion");
    ackerr_clear_a: assert property ($rose(busy_reg) |-> !ackerr_reg)
        else $error("ack error survived a new start");
    done_clear_a: assert property ($rose(busy_reg) |-> !done_reg)
        else $error("done flag survived a new start");
    nack_flag_a: assert property (state_reg == I2CM_ACK && tick && q_reg == 2'd2 && sending && sda_s
        |=> ackerr_reg)
        else $error("slave nack not flagged");
    tx_primary_a: assert property (state_reg == I2CM_SHIFT && byte_reg == 2'd1 && !dir_reg && tick && q_reg == 2'd0
        |=> sda_oe_reg == !tx_pri_reg[bit_reg])
        else $error("first data bit does not match primary byte");
    tx_second_a: assert property (state_reg == I2CM_SHIFT && byte_reg == 2'd2 && !dir_reg && tick && q_reg == 2'd0
        |=> sda_oe_reg == !tx_sec_reg[bit_reg])
        else $error("second data bit does not match secondary byte");
    len_frame_a: assert property (byte_reg == 2'd2 |-> two_reg)
        else $error("second data byte in a one-byte frame");
    addr_dir_a: assert property (state_reg == I2CM_SHIFT && byte_reg == 2'd0 && bit_reg == 3'd0 && tick && q_reg == 2'd0
        |=> sda_oe_reg == !dir_reg)
        else $error("direction bit not sent last in address");
    rx_primary_a: assert property (out_valid && out_ready && !out_word.second
        |=> rx_pri_reg == $past(out_word.data))
        else $error("first read byte not captured");
    rx_second_a: assert property (out_valid && out_ready && out_word.second
        |=> rx_sec_reg == $past(out_word.data))
        else $error("second read byte not captured");
    read_ack_a: assert property (state_reg == I2CM_ACK && !sending && tick && q_reg == 2'd0
        |=> sda_oe_reg == !$past(last))
        else $error("master ack or final nack wrong");
    quarter_bound_a: assert property (qcnt_reg <= 7'(I2CM_QTR_CYCLES - 1))
        else $error("quarter counter overran the time base");

    write_two_c: cover property ($fell(busy_reg) && two_reg && !dir_reg && !ackerr_reg);
    read_two_c: cover property ($fell(busy_reg) && two_reg && dir_reg && !ackerr_reg);
    nack_c: cover property ($fell(busy_reg) && ackerr_reg);
    drain_wait_c: cover property (state_reg == I2CM_DONE && out_valid);
endmodule
`default_nettype wire

// >>> i2cm_slave_model.sv
// Purpose: behavioural i2c slave standing on the far side of the master
// Assumes: open-drain wire levels computed by the bench, pull-ups on both lines
// Notes: no clock stretching of its own; a stop aborts whatever byte is in flight
`timescale 1ns/1ps
`default_nettype none
module i2cm_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic nack_all,
    input wire logic [7:0] rd0,
    input wire logic [7:0] rd1,
    output logic sda_oe,
    output logic [7:0] got0,
    output logic [7:0] got1,
    output logic [7:0] n_got,
    output logic [1:0] m_ack
);
    logic [7:0] sh;
    logic rd_mode;
    logic hit;
    int k;
    int i;
    initial begin
        sda_oe = 1'b0;
        n_got = 8'h00;
        m_ack = 2'b11;
        got0 = 8'h00;
        got1 = 8'h00;
    end
    task automatic rx_byte();
        for (i = 7; i >= 0; i--) begin
            @(posedge scl);
            sh[i] = sda;
        end
    endtask
    task automatic ack(input logic a);
        @(negedge scl);
        sda_oe = a;
        @(negedge scl);
        // in a read the first data bit takes over the line at this edge
        if (!(rd_mode && a)) begin
            sda_oe = 1'b0;
        end
    endtask
    task automatic tx_byte(input logic [7:0] b);
        for (i = 7; i >= 0; i--) begin
            sda_oe = !b[i];
            @(negedge scl);
        end
        sda_oe = 1'b0;
    endtask
    // a stop restarts the frame process so a short write never hangs it
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            disable frm;
            sda_oe = 1'b0;
        end
    end
    always begin : frm
        @(negedge sda iff scl === 1'b1);
        n_got = 8'h00;
        m_ack = 2'b11;
        rx_byte();
        rd_mode = sh[0];
        hit = (sh[7:1] == ADDR) && !nack_all;
        ack(hit);
        if (hit) begin
            for (k = 0; k < 2; k++) begin
                if (rd_mode) begin
                    tx_byte(k == 0 ? rd0 : rd1);
                    @(posedge scl);
                    m_ack[k] = sda;
                    @(negedge scl);
                    if (m_ack[k] !== 1'b0) begin
                        break;
                    end
                end else begin
                    rx_byte();
                    if (k == 0) begin
                        got0 = sh;
                    end else begin
                        got1 = sh;
                    end
                    n_got = n_got + 8'h01;
                    ack(1'b1);
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> test_i2c_master_data_control.sv
// Purpose: self-checking bench for the i2c master data controller
// Assumes: slave model at a fixed address, bench owns the register port
// Notes: frame length bounds allow a few cycles of scl sync stretch per bit
`timescale 1ns/1ps
`default_nettype none
module test_i2c_master_data_control;
    import i2cm_pkg::*;
    localparam logic [6:0] SLV = 7'h2a;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] sfr_addr = 16'h0000;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic transfer_done_flag;
    logic scl_out, scl_oe, sda_out, sda_oe, s_oe;
    logic nack_all = 1'b0;
    logic [7:0] rd0 = 8'h00;
    logic [7:0] rd1 = 8'h00;
    logic [7:0] got0, got1, n_got, v;
    logic [1:0] m_ack;
    logic scl_w, sda_w;
    int n_errors = 0;
    int n_compared = 0;
    int cyc;
    assign scl_w = !scl_oe;
    assign sda_w = !(sda_oe || s_oe);
    always #4 clk_sys = ~clk_sys;
    i2cm_core i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .transfer_done_flag(transfer_done_flag),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
    i2cm_slave_model #(.ADDR(SLV)) i_slave (.scl(scl_w), .sda(sda_w), .nack_all(nack_all), .rd0(rd0),
        .rd1(rd1), .sda_oe(s_oe), .got0(got0), .got1(got1), .n_got(n_got), .m_ack(m_ack));
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask
    task automatic start_frame(input logic [7:0] tgt, input logic [7:0] ctl);
        wr(I2CM_TARGET_OFF, tgt);
        wr(I2CM_CTRL_OFF, ctl);
        rd(I2CM_CTRL_OFF, v);
        chk("status after start", {30'h0, 1'b1, ctl[0]}, v);
        chk("done flag at start", 1'b0, transfer_done_flag);
    endtask
    // this task touches no register; it only polls the done flag until the frame has ended
    task automatic wait_done();
        cyc = 0;
        while (transfer_done_flag !== 1'b1 && cyc < 20000) begin
            @(posedge clk_sys);
            #1;
            cyc++;
        end
        chk("done flag at end", 1'b1, transfer_done_flag);
    endtask
    task automatic t_reset();
        // start bit kept clear here so no frame runs during the sweep
        for (int a = 0; a < 7; a++) begin
            wr(I2CM_TARGET_OFF + 16'(a), (a == 5) ? 8'hfd : 8'hff);
        end
        for (int a = 3; a < 7; a++) begin
            rd(I2CM_TARGET_OFF + 16'(a), v);
            chk("read-only or unmapped", a == 5 ? 32'h1 : 32'h0, v);
        end
        chk("open-drain drive values", 0, {scl_out, sda_out});
        wr(I2CM_CTRL_OFF, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_write(input logic [7:0] ctl, input logic [7:0] b0, input logic [7:0] b1);
        wr(I2CM_TX_PRI_OFF, b0);
        wr(I2CM_TX_SEC_OFF, b1);
        start_frame({SLV, 1'b0}, ctl);
        wr(I2CM_CTRL_OFF, ctl ^ 8'h01);
        wait_done();
        chk("bytes written", ctl[0] ? 2 : 1, n_got);
        chk("first byte", b0, got0);
        if (ctl[0]) begin
            chk("second byte", b1, got1);
        end else begin
            chk("one-byte frame time", 1, cyc >= 6300 && cyc <= 6500);
        end
        rd(I2CM_CTRL_OFF, v);
        chk("status after write", {7'h0, ctl[0]}, v);
        $display("test write len %0d done", ctl[0]);
    endtask
    task automatic t_read(input logic [7:0] ctl, input logic [7:0] b0, input logic [7:0] b1);
        logic [7:0] old;
        rd(I2CM_RX_SEC_OFF, old);
        rd0 <= b0;
        rd1 <= b1;
        start_frame({SLV, 1'b1}, ctl);
        // back-to-back rx reads pause the drain while bytes queue
        @(posedge clk_sys);
        sfr_addr <= I2CM_RX_PRI_OFF;
        sfr_rd <= 1'b1;
        repeat (10000) @(posedge clk_sys);
        sfr_rd <= 1'b0;
        @(negedge clk_sys);
        chk("done held while drain paused", 1'b0, transfer_done_flag);
        wait_done();
        rd(I2CM_RX_PRI_OFF, v);
        chk("first read byte", b0, v);
        rd(I2CM_RX_SEC_OFF, v);
        chk("second read byte", ctl[0] ? b1 : old, v);
        chk("master ack pattern", ctl[0] ? 2'b10 : 2'b11, m_ack);
        $display("test read len %0d done", ctl[0]);
    endtask
    task automatic t_nack();
        nack_all <= 1'b1;
        start_frame({SLV, 1'b0}, 8'h03);
        wait_done();
        rd(I2CM_CTRL_OFF, v);
        chk("ack error set", 8'h05, v);
        chk("bytes after nack", 0, n_got);
        nack_all <= 1'b0;
        t_write(8'h03, 8'h81, 8'h7e);
        $display("test nack done");
    endtask
    initial begin
        #600000;
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        t_write(8'h02, 8'ha5, 8'h5a);
        t_write(8'h03, 8'h3c, 8'hc3);
        t_read(8'h03, 8'h96, 8'h69);
        t_read(8'h02, 8'h17, 8'he8);
        t_nack();
        wrap_up();
    end
endmodule
`default_nettype wire
